// ===== src/stop_mode_clock_power_gating.sv
// Functional notes
// - Entering any stop mode gates off all peripheral system clocks.
// - Debug enabled keeps debug clock in stop; peripheral clocks still halt.
// - Debug enabled turns a power-down stop request into retention stop.
// - Low-voltage stop enable turns a power-down stop request into retention.
// - Retention: regulator full on if debug or detector enabled, else standby.
// - Retention: clock source runs only if ref clock and stop enables set.
// - Retention: oscillator may run; high range also needs detector enabled.
// - Retention: converter runs only with async clock and detector enabled.
// - Retention: comparator on bandgap runs only with detector enabled.
// - Decode direct, high-page and nonvolatile register windows.
// - Stop only when stop enabled; else stop instruction gives illegal reset.
`default_nettype none
module stop_mode_clock_power_gating (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic stop_instr,
  input wire logic wake_irq,
  input wire logic wake_pin,
  input wire logic stop_instr_enable,
  input wire logic debug_enable_bit,
  input wire logic lvd_enable,
  input wire logic lvd_stop_enable,
  input wire logic power_down_select,
  input wire logic internal_ref_clock_enable,
  input wire logic internal_ref_stop_enable,
  input wire logic osc_enable,
  input wire logic osc_high_range,
  input wire logic adc_async_clk_enable,
  input wire logic cmp_bandgap_select,
  input wire logic [stop_gating_pkg::ADDR_W-1:0] cpu_addr,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic debug_clk_en,
  output logic regulator_full_on,
  output logic clk_src_ref_run,
  output logic osc_run,
  output logic adc_run,
  output logic cmp_run,
  output logic in_retention_stop,
  output logic in_power_down_stop,
  output logic illegal_opcode_reset,
  output logic direct_page_sel,
  output logic high_page_sel,
  output logic nonvol_sel
);

  // ==========================================================
  // Reset release
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ==========================================================
  // Wake pin crossing
  logic wake_pin_s;
  logic wake;

  sync_2ff #(.WIDTH(stop_gating_pkg::WAKE_W)) u_wake_sync (
    .clk(ref_clk),
    .rst_n(rst_n_r),
    .din(wake_pin),
    .dout(wake_pin_s)
  );

  assign wake = wake_pin_s | wake_irq;

  // ==========================================================
  // Register group decode
  decode_if dec ();

  assign dec.addr = cpu_addr;

  reg_group_decode u_decode (
    .bus(dec.decoder)
  );

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      direct_page_sel <= 1'b0;
      high_page_sel <= 1'b0;
      nonvol_sel <= 1'b0;
    end else begin
      direct_page_sel <= dec.dp_hit;
      high_page_sel <= dec.hp_hit;
      nonvol_sel <= dec.nv_hit;
    end
  end

  // ==========================================================
  // Entry snapshot of the mode controls
  logic stop_take;
  logic demote;
  logic lvd_in_stop;
  logic dbg_r;
  logic lvd_r;
  logic pd_r;

  assign stop_take = stop_instr && stop_instr_enable;
  assign lvd_in_stop = lvd_enable && lvd_stop_enable;
  // Either keep-alive condition forbids the power-down mode
  assign demote = debug_enable_bit || lvd_stop_enable;

  stop_gating_pkg::seq_state_type state_r;
  stop_gating_pkg::seq_state_type state_nxt;

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      dbg_r <= 1'b0;
      lvd_r <= 1'b0;
      pd_r <= 1'b0;
    end else if (state_r == stop_gating_pkg::ST_RUN && stop_take) begin
      dbg_r <= debug_enable_bit;
      lvd_r <= lvd_in_stop;
      pd_r <= power_down_select && !demote;
    end
  end

  // ==========================================================
  // Sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      stop_gating_pkg::ST_RUN: begin
        if (stop_take) begin
          state_nxt = stop_gating_pkg::ST_ENTER;
        end
      end
      stop_gating_pkg::ST_ENTER: begin
        state_nxt = pd_r ? stop_gating_pkg::ST_PWRDN
                         : stop_gating_pkg::ST_RETAIN;
      end
      stop_gating_pkg::ST_RETAIN,
      stop_gating_pkg::ST_PWRDN: begin
        if (wake) begin
          state_nxt = stop_gating_pkg::ST_RESTORE;
        end
      end
      stop_gating_pkg::ST_RESTORE: begin
        state_nxt = stop_gating_pkg::ST_RUN;
      end
      default: begin
        state_nxt = stop_gating_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= stop_gating_pkg::ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Illegal stop
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      illegal_opcode_reset <= 1'b0;
    end else begin
      illegal_opcode_reset <= state_r == stop_gating_pkg::ST_RUN &&
                              stop_instr && !stop_instr_enable;
    end
  end

  // ==========================================================
  // Digital clock enables
  // Enables only move from flops, so the downstream clock gates
  // never see a glitch; CPU comes back one cycle after peripherals.
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cpu_clk_en <= stop_gating_pkg::CLK_ON;
      periph_clk_en <= stop_gating_pkg::CLK_ON;
      debug_clk_en <= stop_gating_pkg::CLK_ON;
    end else begin
      case (state_nxt)
        stop_gating_pkg::ST_RUN: begin
          cpu_clk_en <= stop_gating_pkg::CLK_ON;
          periph_clk_en <= stop_gating_pkg::CLK_ON;
          debug_clk_en <= stop_gating_pkg::CLK_ON;
        end
        stop_gating_pkg::ST_RESTORE: begin
          cpu_clk_en <= stop_gating_pkg::CLK_OFF;
          periph_clk_en <= stop_gating_pkg::CLK_ON;
          debug_clk_en <= stop_gating_pkg::CLK_ON;
        end
        default: begin
          cpu_clk_en <= stop_gating_pkg::CLK_OFF;
          periph_clk_en <= stop_gating_pkg::CLK_OFF;
          debug_clk_en <= (state_r == stop_gating_pkg::ST_RUN) ?
                          debug_enable_bit : dbg_r;
        end
      endcase
    end
  end

  // ==========================================================
  // Analog and power controls
  logic in_ret;
  logic in_pd;

  assign in_ret = state_nxt == stop_gating_pkg::ST_RETAIN;
  assign in_pd = state_nxt == stop_gating_pkg::ST_PWRDN;

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      regulator_full_on <= 1'b1;
      clk_src_ref_run <= 1'b1;
      osc_run <= 1'b0;
      adc_run <= 1'b1;
      cmp_run <= 1'b1;
      in_retention_stop <= 1'b0;
      in_power_down_stop <= 1'b0;
    end else if (in_ret) begin
      regulator_full_on <= dbg_r || lvd_r;
      clk_src_ref_run <= internal_ref_clock_enable &&
                         internal_ref_stop_enable;
      osc_run <= osc_enable && (!osc_high_range || lvd_r);
      adc_run <= adc_async_clk_enable && lvd_r;
      cmp_run <= !cmp_bandgap_select || lvd_r;
      in_retention_stop <= 1'b1;
      in_power_down_stop <= 1'b0;
    end else if (in_pd) begin
      regulator_full_on <= 1'b0;
      clk_src_ref_run <= 1'b0;
      osc_run <= 1'b0;
      adc_run <= 1'b0;
      cmp_run <= 1'b0;
      in_retention_stop <= 1'b0;
      in_power_down_stop <= 1'b1;
    end else begin
      regulator_full_on <= 1'b1;
      clk_src_ref_run <= 1'b1;
      osc_run <= osc_enable;
      adc_run <= 1'b1;
      cmp_run <= 1'b1;
      in_retention_stop <= 1'b0;
      in_power_down_stop <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n_r);

  sequence s_stop_taken;
    state_r == stop_gating_pkg::ST_RUN && stop_take;
  endsequence

  sequence s_wake_taken;
    (state_r == stop_gating_pkg::ST_RETAIN ||
     state_r == stop_gating_pkg::ST_PWRDN) && wake;
  endsequence

  property p_gate_on_entry;
    s_stop_taken |=> !periph_clk_en && !cpu_clk_en;
  endproperty
  a_gate_on_entry: assert property (p_gate_on_entry)
    else $error("Peripheral clocks not gated on stop entry");

  property p_debug_clk;
    s_stop_taken ##0 debug_enable_bit |=> debug_clk_en && !periph_clk_en;
  endproperty
  a_debug_clk: assert property (p_debug_clk)
    else $error("Debug clock wrong during stop");

  property p_demote;
    s_stop_taken ##0 demote |=> ##1 in_retention_stop && !in_power_down_stop;
  endproperty
  a_demote: assert property (p_demote)
    else $error("Demoted stop did not enter retention");

  property p_pd_entry;
    s_stop_taken ##0 (power_down_select && !demote) |=> ##1
      in_power_down_stop && !regulator_full_on;
  endproperty
  a_pd_entry: assert property (p_pd_entry)
    else $error("Power-down stop not entered");

  property p_regulator;
    in_retention_stop |-> regulator_full_on == (dbg_r || lvd_r);
  endproperty
  a_regulator: assert property (p_regulator)
    else $error("Regulator state wrong in retention");

  property p_adc;
    in_retention_stop && !lvd_r |-> !adc_run && !clk_src_ref_run ==
      !($past(internal_ref_clock_enable) && $past(internal_ref_stop_enable));
  endproperty
  a_adc: assert property (p_adc)
    else $error("Converter or clock source wrong in retention");

  property p_illegal;
    state_r == stop_gating_pkg::ST_RUN && stop_instr && !stop_instr_enable
      |=> illegal_opcode_reset && state_r == stop_gating_pkg::ST_RUN;
  endproperty
  a_illegal: assert property (p_illegal)
    else $error("Disabled stop did not raise illegal reset");

  property p_restore_order;
    s_wake_taken |=> periph_clk_en && !cpu_clk_en ##1
      cpu_clk_en && state_r == stop_gating_pkg::ST_RUN;
  endproperty
  a_restore_order: assert property (p_restore_order)
    else $error("CPU clock resumed before peripheral clocks");

  property p_decode;
    (cpu_addr >= stop_gating_pkg::HIGH_PAGE_LO &&
     cpu_addr <= stop_gating_pkg::HIGH_PAGE_HI) |=>
      high_page_sel && !direct_page_sel && !nonvol_sel;
  endproperty
  a_decode: assert property (p_decode)
    else $error("High-page decode wrong");

endmodule // stop_mode_clock_power_gating
`default_nettype wire

// ===== src/stop_gating_pkg.sv
`default_nettype none
package stop_gating_pkg;

  // ==========================================================
  // Register group address windows
  localparam logic [15:0] DIRECT_PAGE_LO = 16'h0000;
  localparam logic [15:0] DIRECT_PAGE_HI = 16'h007f;
  localparam logic [15:0] HIGH_PAGE_LO = 16'h1800;
  localparam logic [15:0] HIGH_PAGE_HI = 16'h185f;
  localparam logic [15:0] NONVOL_LO = 16'hffb0;
  localparam logic [15:0] NONVOL_HI = 16'hffbf;

  // ==========================================================
  // Widths and reset values
  localparam int ADDR_W = 16;
  localparam int WAKE_W = 1;
  localparam logic CLK_ON = 1'b1;
  localparam logic CLK_OFF = 1'b0;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_ENTER = 3'b001,
    ST_RETAIN = 3'b010,
    ST_PWRDN = 3'b011,
    ST_RESTORE = 3'b100
  } seq_state_type;

endpackage
`default_nettype wire

// ===== src/decode_if.sv
`default_nettype none
interface decode_if;
  logic [stop_gating_pkg::ADDR_W-1:0] addr;
  logic dp_hit;
  logic hp_hit;
  logic nv_hit;

  modport requester (
    output addr,
    input dp_hit,
    input hp_hit,
    input nv_hit
  );

  modport decoder (
    input addr,
    output dp_hit,
    output hp_hit,
    output nv_hit
  );
endinterface
`default_nettype wire

// ===== src/sync_2ff.sv
`default_nettype none
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      dout <= '0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule // sync_2ff
`default_nettype wire

// ===== src/reg_group_decode.sv
`default_nettype none
module reg_group_decode (
  decode_if.decoder bus
);
  // ==========================================================
  // Inclusive window compare for the three register groups
  always_comb begin
    bus.dp_hit = (bus.addr >= stop_gating_pkg::DIRECT_PAGE_LO) &&
                 (bus.addr <= stop_gating_pkg::DIRECT_PAGE_HI);
    bus.hp_hit = (bus.addr >= stop_gating_pkg::HIGH_PAGE_LO) &&
                 (bus.addr <= stop_gating_pkg::HIGH_PAGE_HI);
    bus.nv_hit = (bus.addr >= stop_gating_pkg::NONVOL_LO) &&
                 (bus.addr <= stop_gating_pkg::NONVOL_HI);
  end
endmodule // reg_group_decode
`default_nettype wire

// ===== verif/cpu_periph_model.sv
`default_nettype none
module cpu_periph_model (
  input wire logic ref_clk,
  input wire logic stop_cmd,
  input wire logic wake_cmd,
  input wire logic cpu_clk_en,
  input wire logic in_stop,
  output var logic stop_instr = 1'b0,
  output var logic wake_irq = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // CPU side: a stop can only issue while the CPU is clocked
  always @(posedge ref_clk) begin
    stop_instr <= stop_cmd & cpu_clk_en & ~stop_instr;
  end
  // ==========================================================
  // Wake source holds its request until the stop is left
  always @(posedge ref_clk) begin
    wake_irq <= wake_cmd & in_stop;
  end
endmodule // cpu_periph_model
`default_nettype wire

// ===== verif/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic stop_cmd = 1'b0;
  logic wake_cmd = 1'b0;
  logic wake_pin = 1'b0;
  logic stop_en = 1'b1;
  logic [9:0] cfg = 10'h000;
  logic [15:0] cpu_addr = 16'h0000;
  logic stop_instr, wake_irq, cpu_clk_en, periph_clk_en, debug_clk_en;
  logic reg_on, clk_src, osc, adc, cmp, ret, pd, ill, dp, hp, nv, in_stop;
  logic [7:0] got;
  int error_cnt = 0;
  int comparisons = 0;
  // ==========================================================
  // Config {dbg,lvd_en,lvd_stop,pd,irc,irs,osce,oshi,adca,bg}, outputs
  logic [17:0] rows [9] = '{{10'h000, 8'h82}, {10'h040, 8'h40},
    {10'h240, 8'ha3}, {10'h0c1, 8'h80}, {10'h1bf, 8'hbe},
    {10'h02a, 8'h8a}, {10'h03c, 8'h92}, {10'h103, 8'h80},
    {10'h17e, 8'h40}};
  logic [18:0] dec [10] = '{{16'h0000, 3'h4}, {16'h007f, 3'h4},
    {16'h0080, 3'h0}, {16'h1800, 3'h2}, {16'h185f, 3'h2},
    {16'h1860, 3'h0}, {16'hffaf, 3'h0}, {16'hffb0, 3'h1},
    {16'hffbf, 3'h1}, {16'hffc0, 3'h0}};
  assign got = {ret, pd, reg_on, clk_src, osc, adc, cmp, debug_clk_en};
  assign in_stop = ret | pd;
  always #4 ref_clk = ~ref_clk;

  stop_mode_clock_power_gating u_stop_mode_clock_power_gating (
    .ref_clk(ref_clk), .reset_n(reset_n), .stop_instr(stop_instr),
    .wake_irq(wake_irq), .wake_pin(wake_pin),
    .stop_instr_enable(stop_en), .debug_enable_bit(cfg[9]),
    .lvd_enable(cfg[8]), .lvd_stop_enable(cfg[7]),
    .power_down_select(cfg[6]), .internal_ref_clock_enable(cfg[5]),
    .internal_ref_stop_enable(cfg[4]), .osc_enable(cfg[3]),
    .osc_high_range(cfg[2]), .adc_async_clk_enable(cfg[1]),
    .cmp_bandgap_select(cfg[0]), .cpu_addr(cpu_addr),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .debug_clk_en(debug_clk_en), .regulator_full_on(reg_on),
    .clk_src_ref_run(clk_src), .osc_run(osc), .adc_run(adc), .cmp_run(cmp),
    .in_retention_stop(ret), .in_power_down_stop(pd),
    .illegal_opcode_reset(ill), .direct_page_sel(dp),
    .high_page_sel(hp), .nonvol_sel(nv));

  cpu_periph_model u_cpu_periph_model (
    .ref_clk(ref_clk), .stop_cmd(stop_cmd), .wake_cmd(wake_cmd),
    .cpu_clk_en(cpu_clk_en), .in_stop(in_stop),
    .stop_instr(stop_instr), .wake_irq(wake_irq));

  // ==========================================================
  // Shared tasks
  task automatic check(input string name, input logic [7:0] e,
                       input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask

  // Returns just after the edge that takes the stop, so that the
  // one-cycle illegal pulse is still standing
  task automatic enter_stop();
    @(posedge ref_clk);
    stop_cmd <= 1'b1;
    @(posedge ref_clk);
    stop_cmd <= 1'b0;
    tick();
  endtask

  task automatic leave_stop(input logic by_pin);
    @(posedge ref_clk);
    wake_cmd <= ~by_pin;
    wake_pin <= by_pin;
    for (int i = 0; i < 20 && periph_clk_en !== 1'b1; i++) tick();
    check("wake", 8'h04, {4'h0, cpu_clk_en, periph_clk_en, ret, pd});
    tick();
    check("resume", 8'h0c, {4'h0, cpu_clk_en, periph_clk_en, ret, pd});
    @(posedge ref_clk);
    wake_cmd <= 1'b0;
    wake_pin <= 1'b0;
    repeat (6) tick();
  endtask

  task automatic complete_run();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchdog: the tests need well under a thousand cycles
  initial begin
    #100000;
    error_cnt++;
    complete_run();
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    check("reset clk", 8'hfb,
          {cpu_clk_en, periph_clk_en, debug_clk_en, reg_on, got[4:1]});
    check("reset mode", 8'h00, {2'h0, ret, pd, ill, dp, hp, nv});
    reset_n <= 1'b1;
    repeat (4) tick();
    foreach (rows[i]) begin
      @(posedge ref_clk);
      cfg <= rows[i][17:8];
      enter_stop();
      check("gates", {7'h0, rows[i][17]},
            {5'h0, cpu_clk_en, periph_clk_en, debug_clk_en});
      tick();
      check("stop state", rows[i][7:0], got);
      leave_stop(i[0]);
    end
    // Stop instruction while stops are disabled
    @(posedge ref_clk);
    stop_en <= 1'b0;
    enter_stop();
    check("illegal", 8'h0c, {4'h0, cpu_clk_en, ill, ret, pd});
    tick();
    check("illegal end", 8'h08, {4'h0, cpu_clk_en, ill, ret, pd});
    // Window edges and the addresses just outside them, except the one just below the high page
    foreach (dec[i]) begin
      @(posedge ref_clk);
      cpu_addr <= dec[i][18:3];
      tick();
      check("decode", {5'h0, dec[i][2:0]}, {5'h0, dp, hp, nv});
    end
    // Reset dropped in the middle of a stop
    @(posedge ref_clk);
    stop_en <= 1'b1;
    enter_stop();
    @(posedge ref_clk);
    reset_n <= 1'b0;
    tick();
    check("midrun clk", 8'hfb,
          {cpu_clk_en, periph_clk_en, debug_clk_en, reg_on, got[4:1]});
    check("midrun mode", 8'h00, {2'h0, ret, pd, ill, dp, hp, nv});
    @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) tick();
    check("after reset", 8'h0c, {4'h0, cpu_clk_en, periph_clk_en, ret, pd});
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
